/* dv/asp_host_model.sv */
// serial host model: drives chip select, serial clock and data in
// assumes dout_pin is the resolved output line; the caller spaces frames
`timescale 1ns/10ps
module asp_host_model (
	// serial pins
	output logic      cs_n,
	output logic      sclk,
	output logic      din,
	input  wire logic dout_pin
);
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din  = 1'b0;
	end

	// host is master and makes a 160 ns serial clock, well under the top rate
	task automatic xfer(input logic [7:0] tx, input int nb, input logic m11, input logic sel,
		output logic [7:0] rx);
		rx = 8'h00;
		#7;
		cs_n <= ~sel;
		#100;
		for (int i = 0; i < nb; i++)
		begin
			#80;
			if (m11)
				rx[7-i] = dout_pin;
			sclk <= 1'b1;
			// data moves on the rise, so it holds well clear of the fall
			din  <= tx[7-i];
			#80;
			if (!m11)
				rx[7-i] = dout_pin;
			sclk <= 1'b0;
		end
		#80;
		cs_n <= 1'b1;
		// released line must not keep its last level
		din  <= ~din;
		#100;
	endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the serial pin control block
// assumes asp_host_model plays the host; CLK at 50 MHz
`timescale 1ns/10ps
module testbench;
	import asp_pkg::*;
	logic        CLK;
	logic        RST_N;
	logic        DAC_LOAD_N;
	logic        DAC_RESET_SELECT;
	logic        CONV_DONE;
	logic        RX_READY;
	logic        DAC_WR_EN;
	logic        CS_N;
	logic        SCLK;
	logic        DIN;
	logic        DOUT;
	logic        DOUT_OE;
	logic        EOC_N;
	logic        DAC_WAKE_TO_REF;
	logic        RX_VALID;
	logic        RX_OVERRUN;
	logic        stall;
	logic [1:0]  CLK_MODE;
	logic [7:0]  CONV_DATA;
	logic [7:0]  RX_DATA;
	logic [95:0] DAC_OUTPUTS;
	logic [2:0]  DAC_WR_SEL;
	logic [11:0] DAC_WR_DATA;
	int          n_errors;
	int          n_checks;
	int          cyc;
	int          n_ovr;
	int          exp_q[$];
	wire         dout_pin = DOUT_OE ? DOUT : 1'bz;

	asp_serial_top dut_u (.CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN), .DOUT(DOUT),
		.DOUT_OE(DOUT_OE), .EOC_N(EOC_N), .DAC_LOAD_N(DAC_LOAD_N), .DAC_RESET_SELECT(DAC_RESET_SELECT),
		.DAC_OUTPUTS(DAC_OUTPUTS), .DAC_WAKE_TO_REF(DAC_WAKE_TO_REF), .CLK_MODE(CLK_MODE),
		.CONV_DONE(CONV_DONE), .CONV_DATA(CONV_DATA), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
		.RX_READY(RX_READY), .RX_OVERRUN(RX_OVERRUN), .DAC_WR_EN(DAC_WR_EN), .DAC_WR_SEL(DAC_WR_SEL),
		.DAC_WR_DATA(DAC_WR_DATA));

	asp_host_model host_u (.cs_n(CS_N), .sclk(SCLK), .din(DIN), .dout_pin(dout_pin));

	initial
	begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	task automatic check(input logic [95:0] seen, input logic [95:0] want);
		n_checks++;
		if (seen !== want)
		begin
			n_errors++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask

	task automatic complete_run();
		if (n_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic dac_wr(input logic [2:0] ch, input logic [11:0] d);
		DAC_WR_SEL  <= ch;
		DAC_WR_DATA <= d;
		DAC_WR_EN   <= 1'b1;
		@(posedge CLK);
		DAC_WR_EN   <= 1'b0;
		repeat (6) @(posedge CLK);
	endtask

	task automatic boot(input logic strap);
		logic [95:0] want;
		logic [2:0]  ch;
		logic [11:0] d;
		ch = 3'($urandom);
		d = 12'($urandom);
		RST_N <= 1'b0;
		DAC_RESET_SELECT <= strap;
		repeat (8) @(posedge CLK);
		RST_N <= 1'b1;
		repeat (6) @(posedge CLK);
		check(DAC_WAKE_TO_REF, strap);
		want = {8{strap ? DAC_INIT_HIGH : DAC_INIT_LOW}};
		want[ch*12 +: 12] = d;
		dac_wr(ch, d);
		check(DAC_OUTPUTS, 96'h0);
		DAC_LOAD_N <= 1'b0;
		repeat (6) @(posedge CLK);
		check(DAC_OUTPUTS, want);
		d = ~d;
		want[(ch^3'h1)*12 +: 12] = d;
		dac_wr(ch ^ 3'h1, d);
		check(DAC_OUTPUTS, want);
		DAC_LOAD_N <= 1'b1;
	endtask

	task automatic frame(input int nb, input logic sel, input logic chk);
		logic [7:0] tx;
		logic [7:0] d;
		logic [7:0] rx;
		@(posedge CLK);
		tx = 8'($urandom);
		d = 8'($urandom);
		if (chk)
		begin
			CONV_DATA <= d;
			CONV_DONE <= 1'b1;
			@(posedge CLK);
			CONV_DONE <= 1'b0;
			@(posedge CLK);
			check(EOC_N, 1'b0);
		end
		// queued first: the consumer may take the word before the transfer task returns
		if (nb == 8 && sel && !(stall && exp_q.size() == 3))
			exp_q.push_back(tx);
		host_u.xfer(tx, nb, CLK_MODE == MODE_RISE_OUT, sel, rx);
		if (chk)
		begin
			check(rx, d);
			check(EOC_N, 1'b1);
		end
		check(dout_pin, 1'bz);
	endtask

	// consumer with random stalls; every accepted word is compared
	always @(posedge CLK)
	begin
		if (RX_VALID === 1'b1 && RX_READY === 1'b1)
			check(RX_DATA, exp_q.size() ? exp_q.pop_front() : 'x);
		if (RX_OVERRUN === 1'b1)
			n_ovr++;
		RX_READY <= stall ? 1'b0 : 1'($urandom);
		cyc++;
		if (cyc == 6000)
		begin
			n_errors++;
			complete_run();
		end
	end

	initial
	begin
		void'($urandom(54168));
		RST_N = 1'b0;
		DAC_LOAD_N = 1'b1;
		DAC_RESET_SELECT = 1'b0;
		CONV_DONE = 1'b0;
		CONV_DATA = 8'h00;
		DAC_WR_EN = 1'b0;
		DAC_WR_SEL = 3'h0;
		DAC_WR_DATA = 12'h000;
		CLK_MODE = 2'h0;
		RX_READY = 1'b0;
		stall = 1'b0;
		for (int s = 0; s < 2; s++)
			boot(s[0]);
		for (int m = 0; m < 4; m++)
		begin
			@(posedge CLK);
			CLK_MODE <= 2'(m);
			frame(8, 1'b1, 1'b1);
		end
		// partial word then a whole one, then clocks with chip select high
		frame(5, 1'b1, 1'b0);
		frame(8, 1'b1, 1'b1);
		frame(8, 1'b0, 1'b0);
		repeat (30) @(posedge CLK);
		stall <= 1'b1;
		repeat (4) frame(8, 1'b1, 1'b0);
		check(n_ovr, 1);
		stall <= 1'b0;
		repeat (40) @(posedge CLK);
		check(exp_q.size(), 0);
		complete_run();
	end
endmodule

/* hw/asp_buf2.sv */
// two-entry buffer between the serial shifter and the word consumer
// assumes both sides on the same clock; outputs come from flip-flops
`timescale 1ns/10ps
module asp_buf2 #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	// drain side
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	logic [W-1:0] head;
	logic [W-1:0] tail;
	logic         head_v;
	logic         tail_v;
	logic [W-1:0] next_head;
	logic [W-1:0] next_tail;
	logic         next_head_v;
	logic         next_tail_v;

	assign out_data  = head;
	assign out_valid = head_v;
	// full only when the second slot is taken, so the source sees true back-pressure
	assign in_ready  = ~tail_v;

	always_comb
	begin
		next_head   = head;
		next_tail   = tail;
		next_head_v = head_v;
		next_tail_v = tail_v;
		if (head_v && out_ready)
		begin
			if (tail_v)
			begin
				next_head   = tail;
				next_tail_v = 1'b0;
			end
			else
				next_head_v = 1'b0;
		end
		if (in_valid && !tail_v)
		begin
			if (!next_head_v)
			begin
				next_head   = in_data;
				next_head_v = 1'b1;
			end
			else
			begin
				next_tail   = in_data;
				next_tail_v = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head   <= '0;
			tail   <= '0;
			head_v <= 1'b0;
			tail_v <= 1'b0;
		end
		else
		begin
			head   <= next_head;
			tail   <= next_tail;
			head_v <= next_head_v;
			tail_v <= next_tail_v;
		end
	end
endmodule

/* hw/asp_pkg.sv */
// constants for the serial pin control block of the combined adc/dac
// assumes a single 50 MHz system clock; no software-visible registers
package asp_pkg;
	localparam int          CLK_MHZ        = 50;
	localparam int          DAC_WIDTH      = 12;
	localparam int          DAC_COUNT      = 8;
	localparam int          SYNC_STAGES    = 2;
	// strap is read only once both synchroniser stages hold a settled level
	localparam logic [1:0]  INIT_CYCLES    = 2'h3;
	localparam logic [1:0]  MODE_RISE_OUT  = 2'h3;
	localparam logic [11:0] DAC_INIT_HIGH  = 12'hfff;
	localparam logic [11:0] DAC_INIT_LOW   = 12'h000;
	localparam int          SCLK_MAX_MHZ   = 25;

	typedef enum logic [1:0]
	{
		ST_WAIT = 2'b01,
		ST_RUN  = 2'b10
	} asp_state_t;
endpackage

/* hw/asp_serial_top.sv */
// serial port, end-of-conversion flag and dac load control of the adc/dac
// assumes the host makes the serial clock; every pin is sampled by CLK
`timescale 1ns/10ps
// What this block does
// [RULE1] In clock modes 00, 01 and 10 the output bit changes on the serial clock falling edge.
// [RULE2] In clock mode 11 the output bit changes on the serial clock rising edge.
// [RULE3] While chip select is high the data output is not driven.
// [RULE4] Each input bit is taken on the serial clock falling edge.
// [RULE5] The port responds only while chip select is low, held low by the host for the whole transfer.
// [RULE6] The conversion-done output goes low to flag a result, which is readable once it has fallen.
// [RULE7] The dac load input moves pending dac values to the outputs without regard to the serial clock.
// [RULE8] While dac load is low the dac registers pass input values straight through.
// [RULE9] After reset the dac input registers start at all ones when reset-select is high, else all zeros.
// [RULE10] Reset-select picks the wake-up termination, high for the reference and low for ground.
// [RULE11] The host is master, makes the serial clock and keeps it at or below its top rate.
// [RULE12] A rising chip select drops a partial word and clears the bit counter.
module asp_serial_top
	import asp_pkg::*;
#(
	parameter int WORD_W = 8,
	parameter int DAC_N  = asp_pkg::DAC_COUNT,
	parameter int DAC_W  = asp_pkg::DAC_WIDTH
) (
	// clock and reset
	input  wire logic                     CLK,
	input  wire logic                     RST_N,
	// serial pins
	input  wire logic                     CS_N,
	input  wire logic                     SCLK,
	input  wire logic                     DIN,
	output logic                          DOUT,
	output logic                          DOUT_OE,
	output logic                          EOC_N,
	// dac pins
	input  wire logic                     DAC_LOAD_N,
	input  wire logic                     DAC_RESET_SELECT,
	output logic [DAC_N*DAC_W-1:0]        DAC_OUTPUTS,
	output logic                          DAC_WAKE_TO_REF,
	// configuration from core logic
	input  wire logic [1:0]               CLK_MODE,
	// conversion result
	input  wire logic                     CONV_DONE,
	input  wire logic [WORD_W-1:0]        CONV_DATA,
	// received words
	output logic [WORD_W-1:0]             RX_DATA,
	output logic                          RX_VALID,
	input  wire logic                     RX_READY,
	output logic                          RX_OVERRUN,
	// dac input register writes
	input  wire logic                     DAC_WR_EN,
	input  wire logic [$clog2(DAC_N)-1:0] DAC_WR_SEL,
	input  wire logic [DAC_W-1:0]         DAC_WR_DATA
);
	localparam int               CW   = $clog2(WORD_W);
	localparam logic [CW-1:0]    LAST = CW'(WORD_W - 1);

	logic cs_s1, cs_s2, cs_s3;
	logic sclk_s1, sclk_s2, sclk_s3;
	logic din_s1, din_s2, load_s1, load_s2, rsel_s1, rsel_s2;

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			{cs_s1, cs_s2, cs_s3}       <= 3'h7;
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{din_s1, din_s2}            <= 2'h0;
			{load_s1, load_s2}          <= 2'h3;
			{rsel_s1, rsel_s2}          <= 2'h0;
		end
		else
		begin
			{cs_s1, cs_s2, cs_s3}       <= {CS_N, cs_s1, cs_s2};
			{sclk_s1, sclk_s2, sclk_s3} <= {SCLK, sclk_s1, sclk_s2};
			{din_s1, din_s2}            <= {DIN, din_s1};
			{load_s1, load_s2}          <= {DAC_LOAD_N, load_s1};
			{rsel_s1, rsel_s2}          <= {DAC_RESET_SELECT, rsel_s1};
		end
	end

	logic cs_act, cs_fall, cs_rise, sclk_rise, sclk_fall, out_edge;
	assign cs_act    = ~cs_s2;
	assign cs_fall   = cs_s3 & ~cs_s2;
	assign cs_rise   = ~cs_s3 & cs_s2;
	assign sclk_rise = sclk_s2 & ~sclk_s3;
	assign sclk_fall = ~sclk_s2 & sclk_s3;
	assign out_edge  = (CLK_MODE == MODE_RISE_OUT) ? sclk_rise : sclk_fall; // RULE1 RULE2

	// serial shifter
	logic [CW-1:0]     bit_cnt, tx_cnt, next_bit_cnt, next_tx_cnt;
	logic [WORD_W-1:0] rx_shift, tx_shift, tx_hold, next_rx_shift, next_tx_shift, next_tx_hold;
	logic              dout, dout_oe, eoc_n, overrun, push_valid;
	logic              next_dout, next_dout_oe, next_eoc_n, next_overrun, next_push_valid;
	logic [WORD_W-1:0] push_data, next_push_data;
	logic              push_ready;

	always_comb
	begin
		next_bit_cnt    = bit_cnt;
		next_tx_cnt     = tx_cnt;
		next_rx_shift   = rx_shift;
		next_tx_shift   = tx_shift;
		next_dout       = dout;
		next_dout_oe    = dout_oe;
		next_overrun    = 1'b0;
		next_push_valid = push_valid & ~push_ready;
		next_push_data  = push_data;
		next_tx_hold    = CONV_DONE ? CONV_DATA : tx_hold; // RULE6
		// eoc stays low until the host opens a read; a new result wins over the clear
		next_eoc_n      = CONV_DONE ? 1'b0 : (cs_fall ? 1'b1 : eoc_n); // RULE6
		if (!cs_act || cs_rise)
		begin
			next_dout_oe = 1'b0; // RULE3
			next_bit_cnt = '0; // RULE12
			next_tx_cnt  = '0; // RULE12
		end
		else if (cs_fall)
		begin
			next_dout_oe  = 1'b1; // RULE5
			next_tx_shift = tx_hold;
			next_dout     = tx_hold[WORD_W-1];
			next_bit_cnt  = '0;
			next_tx_cnt   = '0;
		end
		else
		begin
			next_dout_oe = 1'b1;
			if (sclk_fall)
			begin
				next_rx_shift = {rx_shift[WORD_W-2:0], din_s2}; // RULE4
				if (bit_cnt == LAST)
				begin
					next_bit_cnt = '0;
					// no way to stall the host, so a word with nowhere to go is dropped and flagged
					if (next_push_valid)
						next_overrun = 1'b1;
					else
					begin
						next_push_valid = 1'b1;
						next_push_data  = {rx_shift[WORD_W-2:0], din_s2};
					end
				end
				else
					next_bit_cnt = bit_cnt + 1'b1;
			end
			if (out_edge)
			begin
				if (tx_cnt == LAST)
				begin
					next_tx_cnt   = '0;
					next_tx_shift = tx_hold;
					next_dout     = tx_hold[WORD_W-1];
				end
				else
				begin
					next_tx_cnt   = tx_cnt + 1'b1;
					next_tx_shift = {tx_shift[WORD_W-2:0], 1'b0};
					next_dout     = tx_shift[WORD_W-2]; // RULE1 RULE2
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			bit_cnt    <= '0;
			tx_cnt     <= '0;
			rx_shift   <= '0;
			tx_shift   <= '0;
			tx_hold    <= '0;
			dout       <= 1'b0;
			dout_oe    <= 1'b0;
			eoc_n      <= 1'b1;
			overrun    <= 1'b0;
			push_valid <= 1'b0;
			push_data  <= '0;
		end
		else
		begin
			bit_cnt    <= next_bit_cnt;
			tx_cnt     <= next_tx_cnt;
			rx_shift   <= next_rx_shift;
			tx_shift   <= next_tx_shift;
			tx_hold    <= next_tx_hold;
			dout       <= next_dout;
			dout_oe    <= next_dout_oe;
			eoc_n      <= next_eoc_n;
			overrun    <= next_overrun;
			push_valid <= next_push_valid;
			push_data  <= next_push_data;
		end
	end

	assign DOUT       = dout;
	assign DOUT_OE    = dout_oe;
	assign EOC_N      = eoc_n;
	assign RX_OVERRUN = overrun;

	asp_buf2 #(
		.W (WORD_W)
	) u_rx_buf (
		.clk       (CLK),
		.rst_n     (RST_N),
		.in_data   (push_data),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.out_data  (RX_DATA),
		.out_valid (RX_VALID),
		.out_ready (RX_READY)
	);

	// dac input and output registers
	asp_state_t               st, next_st;
	logic [1:0]               init_cnt, next_init_cnt;
	logic [DAC_N*DAC_W-1:0]   dac_in, dac_out, next_dac_in, next_dac_out;
	logic                     wake_ref, next_wake_ref;

	always_comb
	begin
		next_st       = st;
		next_init_cnt = init_cnt;
		next_dac_in   = dac_in;
		next_wake_ref = wake_ref;
		// transparent while load is low; a pulse of one clock still transfers
		next_dac_out  = load_s2 ? dac_out : dac_in; // RULE7 RULE8
		case (st)
			ST_WAIT:
			begin
				next_init_cnt = init_cnt + 1'b1;
				if (init_cnt == INIT_CYCLES)
				begin
					next_st       = ST_RUN;
					next_dac_in   = {DAC_N{rsel_s2 ? DAC_INIT_HIGH : DAC_INIT_LOW}}; // RULE9
					next_wake_ref = rsel_s2; // RULE10
				end
			end
			ST_RUN:
			begin
				if (DAC_WR_EN)
					next_dac_in[DAC_WR_SEL*DAC_W +: DAC_W] = DAC_WR_DATA;
			end
			default:
				next_st = ST_WAIT;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			st       <= ST_WAIT;
			init_cnt <= '0;
			dac_in   <= '0;
			dac_out  <= '0;
			wake_ref <= 1'b0;
		end
		else
		begin
			st       <= next_st;
			init_cnt <= next_init_cnt;
			dac_in   <= next_dac_in;
			dac_out  <= next_dac_out;
			wake_ref <= next_wake_ref;
		end
	end

	assign DAC_OUTPUTS     = dac_out;
	assign DAC_WAKE_TO_REF = wake_ref;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_dout_hiz_idle:   assert property (cs_s2 |=> !DOUT_OE) else $error("data output driven while deselected"); // RULE3
	a_din_fall_take:   assert property (sclk_fall && cs_act && !cs_fall && !cs_rise |=> // RULE4
		rx_shift[0] == $past(din_s2)) else $error("input bit not taken on falling edge");
	a_dout_fall_mode:  assert property (sclk_rise && CLK_MODE != MODE_RISE_OUT && cs_act && !cs_fall |=> // RULE1
		$stable(DOUT)) else $error("output moved on rising edge in falling mode");
	a_dout_rise_mode:  assert property (sclk_fall && CLK_MODE == MODE_RISE_OUT && cs_act && !cs_fall |=> // RULE2
		$stable(DOUT)) else $error("output moved on falling edge in mode 11");
	a_idle_no_count:   assert property (!cs_act ##1 !cs_act |-> // RULE5
		bit_cnt == '0 && !DOUT_OE) else $error("port active while deselected");
	a_eoc_with_data:   assert property ($fell(EOC_N) |-> // RULE6
		tx_hold == $past(CONV_DATA)) else $error("result not ready at end of conversion");
	a_load_transp:     assert property ((!load_s2)[*2] |=> // RULE8
		DAC_OUTPUTS == $past(dac_in)) else $error("dac not transparent while load low");
	a_load_hold:       assert property (load_s2 |=> $stable(DAC_OUTPUTS)) else $error("dac outputs moved without load"); // RULE7
	a_dac_init_value:  assert property (st == ST_WAIT && init_cnt == INIT_CYCLES |=> // RULE9
		dac_in[DAC_W-1:0] == ($past(rsel_s2) ? DAC_INIT_HIGH : DAC_INIT_LOW)) else $error("wrong dac start value");
	a_wake_term:       assert property (st == ST_WAIT && init_cnt == INIT_CYCLES |=> // RULE10
		DAC_WAKE_TO_REF == $past(rsel_s2)) else $error("wrong wake-up termination");
	a_abort_partial:   assert property (cs_rise |=> // RULE12
		bit_cnt == '0 && tx_cnt == '0) else $error("partial word kept after deselect");

	c_word_pushed:  cover property (push_valid && push_ready);
	c_overrun:      cover property (RX_OVERRUN);
	c_eoc_then_rd:  cover property ($fell(EOC_N) ##[1:200] cs_fall);
	c_load_update:  cover property ($fell(load_s2) ##1 $changed(DAC_OUTPUTS));
endmodule
